// [rtl/acksp_pkg.sv]
// acknowledged state-change producer: constants, codes and carrier types
// assumes a 250 MHz ref_clk and a classic wishbone master for the registers
// Contract
// - single-consumer producer trigger code is 13h (state change) or 03h (cyclic).
// - multi-consumer producing connection uses 10h (state change) or 00h (cyclic).
// - multi-consumer setup makes one consuming connection per consumer, code 80h.
// - an established acknowledge-consuming connection joins the pending-responder list.
// - acknowledge-consuming path names the tracker and holds class and instance only.
// - acknowledge data size equals the tracker target's size, or zero without target.
// - multi-consumer producing connection leaves consumed path and size unconfigured.
// - on commit with a valid trigger the producer configures that production mode.
// - unsupported production mode makes commit fail; connection stays unestablished.
// - no new data is sent while the inhibit timer runs.
// - new data is sent only with no acknowledge pending and inhibit idle.
// - each send or retry sets pending until acknowledge timeout or acknowledge.
// - on acknowledge timeout resend old data if nothing new or inhibit running.
// - new send, or resend on trigger timeout, restarts all three timers.
// - each transmission restarting all three timers clears the retry counter.
// - a retry restarts only the acknowledge timer.
// - acknowledge period and retry limit are software configurable.
// - each acknowledge timeout counts a retry; reaching the limit signals the application.
// - a retry leaves the retry counter uncleared; a new send or a resend on trigger timeout clears it.
package acksp_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned TICK_US = 1;
	localparam int unsigned TICK_CYC = CLK_MHZ * TICK_US;
	localparam int unsigned N_CONS = 8;
	localparam logic [7:0] TT_ST_CL3 = 8'h13;
	localparam logic [7:0] TT_CYC_CL3 = 8'h03;
	localparam logic [7:0] TT_SRV_CL3 = 8'h83;
	localparam logic [7:0] TT_ST_CL0 = 8'h10;
	localparam logic [7:0] TT_CYC_CL0 = 8'h00;
	localparam logic [7:0] TT_SRV_CL0 = 8'h80;
	localparam logic [7:0] TRACKER_CLASS = 8'h2B;
	localparam logic [5:0] A_CTRL = 6'h00;
	localparam logic [5:0] A_ACK_PER = 6'h04;
	localparam logic [5:0] A_INH_PER = 6'h08;
	localparam logic [5:0] A_TRG_PER = 6'h0C;
	localparam logic [5:0] A_RETRY = 6'h10;
	localparam logic [5:0] A_TSIZE = 6'h14;
	localparam logic [5:0] A_STATUS = 6'h18;
	localparam logic [5:0] A_CODES = 6'h1C;
	localparam logic [5:0] A_CPATH = 6'h20;
	localparam logic [5:0] A_ESTAB = 6'h24;
	localparam logic [5:0] A_PEND = 6'h28;
	localparam logic [5:0] A_CMD = 6'h2C;
	localparam logic [15:0] ACK_PER_RST = 16'h0064;
	localparam logic [15:0] INH_PER_RST = 16'h000A;
	localparam logic [15:0] TRG_PER_RST = 16'h03E8;
	localparam logic [7:0] RETRY_RST = 8'h03;
	typedef enum logic [1:0] {ACKSP_IDLE, ACKSP_RUN} acksp_mode_t;
	typedef struct packed {
		logic multi;
		logic cyclic;
		logic has_target;
		logic [15:0] target_size;
	} acksp_cfg_t;
	typedef struct packed {
		logic [7:0] prod_code;
		logic [7:0] cons_code;
		logic [15:0] cons_size;
		logic cons_path_set;
	} acksp_conn_t;
endpackage

// [rtl/acksp_timer.sv]
// one restartable down counter on a shared tick
// assumes tick is a one-cycle pulse from the same clock
`timescale 1ns/1ps
module acksp_timer #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control
	input wire logic tick,
	input wire logic restart,
	input wire logic [W-1:0] period,
	// status
	output logic running,
	output logic expire
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (restart) begin
			cnt_q <= period;
		end else if (tick && cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			expire <= 1'b0;
		end else begin
			expire <= !restart && tick && cnt_q == {{(W-1){1'b0}}, 1'b1};
		end
	end
	assign running = cnt_q != '0;
	timer_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		restart && period != '0 |=> running) else $error("timer no load");
endmodule

// [rtl/acksp_list.sv]
// pending-responder list: one bit per consuming connection instance
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
module acksp_list #(
	parameter int N = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control
	input wire logic [N-1:0] member,
	input wire logic arm,
	input wire logic [N-1:0] ack_in,
	// status
	output logic [N-1:0] pend_q,
	output logic all_acked
);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pend_q <= '0;
		end else if (arm) begin
			pend_q <= member; // arm wins over acks of the old send
		end else begin
			pend_q <= pend_q & ~ack_in & member;
		end
	end
	assign all_acked = pend_q == '0;
endmodule

// [rtl/acksp_top.sv]
// acknowledged state-change producer with wishbone register slave
// assumes a classic wishbone master and link logic on ref_clk
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module acksp_top #(
	parameter int N = acksp_pkg::N_CONS,
	parameter int unsigned TICK = acksp_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// producing application
	input wire logic new_data,
	input wire logic support_push,
	input wire logic support_cyclic,
	output logic send_new,
	output logic send_old,
	output logic retry_limit,
	// link side
	input wire logic [N-1:0] ack_rx,
	output acksp_pkg::acksp_conn_t conn_cfg
);
	import acksp_pkg::*;

	logic [31:0] ctrl_q;
	logic [31:0] ack_per_q;
	logic [31:0] inh_per_q;
	logic [31:0] trg_per_q;
	logic [31:0] retry_q;
	logic [31:0] tsize_q;
	logic [N-1:0] estab_q;
	logic [N-1:0] pend;
	logic [7:0] rcnt_q;
	logic [31:0] prediv_q;
	logic tick;
	logic all_acked;
	logic ack_pend_q;
	logic have_new_q;
	logic lim_q;
	logic err_q;
	logic ack_run;
	logic inh_run;
	logic trg_run;
	logic ack_exp;
	logic inh_exp;
	logic trg_exp;
	logic restart_all;
	logic restart_ack;
	logic req;
	logic wr;
	logic commit;
	logic ok_mode;
	acksp_mode_t mode_q;
	acksp_cfg_t cfg;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
		return a == r;
	endfunction

	assign cfg.multi = ctrl_q[1];
	assign cfg.cyclic = ctrl_q[2];
	assign cfg.has_target = tsize_q[16];
	assign cfg.target_size = tsize_q[15:0];

	// bus slave: one wait state, ack dropped after one cycle
	// writes land at the edge where the master samples ack high
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= 32'h0;
			ack_per_q <= {16'h0, ACK_PER_RST};
			inh_per_q <= {16'h0, INH_PER_RST};
			trg_per_q <= {16'h0, TRG_PER_RST};
			retry_q <= {24'h0, RETRY_RST};
			tsize_q <= 32'h0;
			estab_q <= '0;
		end else if (wr) begin
			if (hit(wb_adr_i, A_CTRL) && wb_sel_i[0]) begin
				ctrl_q <= {29'h0, wb_dat_i[2:0]};
			end
			if (hit(wb_adr_i, A_ACK_PER)) begin
				ack_per_q <= {16'h0, wb_dat_i[15:0]};
			end
			if (hit(wb_adr_i, A_INH_PER)) begin
				inh_per_q <= {16'h0, wb_dat_i[15:0]};
			end
			if (hit(wb_adr_i, A_TRG_PER)) begin
				trg_per_q <= {16'h0, wb_dat_i[15:0]};
			end
			if (hit(wb_adr_i, A_RETRY) && wb_sel_i[0]) begin
				retry_q <= {24'h0, wb_dat_i[7:0]};
			end
			if (hit(wb_adr_i, A_TSIZE)) begin
				tsize_q <= {15'h0, wb_dat_i[16:0]};
			end
			if (hit(wb_adr_i, A_ESTAB)) begin
				estab_q <= wb_dat_i[N-1:0];
			end
		end
	end

	// commit: write 1 to bit 0 of the command register
	assign commit = wr && hit(wb_adr_i, A_CMD) && wb_dat_i[0];
	assign ok_mode = cfg.cyclic ? support_cyclic : support_push;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_q <= ACKSP_IDLE;
			err_q <= 1'b0;
		end else if (commit) begin
			case (ok_mode)
				1'b1: begin
					mode_q <= ACKSP_RUN;
					err_q <= 1'b0;
				end
				default: begin
					mode_q <= ACKSP_IDLE;
					err_q <= 1'b1;
				end
			endcase
		end else if (wr && hit(wb_adr_i, A_CMD) && wb_dat_i[1]) begin
			mode_q <= ACKSP_IDLE;
		end
	end

	// connection attribute codes presented to the link
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conn_cfg <= '0;
		end else if (cfg.multi) begin
			conn_cfg.prod_code <= cfg.cyclic ? TT_CYC_CL0 : TT_ST_CL0;
			conn_cfg.cons_code <= TT_SRV_CL0;
			conn_cfg.cons_size <= 16'h0;
			conn_cfg.cons_path_set <= 1'b0;
		end else begin
			conn_cfg.prod_code <= cfg.cyclic ? TT_CYC_CL3 : TT_ST_CL3;
			conn_cfg.cons_code <= TT_SRV_CL3;
			conn_cfg.cons_size <= cfg.has_target ? cfg.target_size : 16'h0;
			conn_cfg.cons_path_set <= 1'b1;
		end
	end
	// shared prescaler
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prediv_q <= 32'h0;
		end else if (prediv_q == TICK - 1) begin
			prediv_q <= 32'h0;
		end else begin
			prediv_q <= prediv_q + 32'h1;
		end
	end
	assign tick = prediv_q == TICK - 1;

	acksp_timer #(.W(16)) u_ack (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(tick),
		.restart(restart_ack),
		.period(ack_per_q[15:0]),
		.running(ack_run),
		.expire(ack_exp)
	);
	acksp_timer #(.W(16)) u_inh (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(tick),
		.restart(restart_all),
		.period(inh_per_q[15:0]),
		.running(inh_run),
		.expire(inh_exp)
	);
	acksp_timer #(.W(16)) u_trg (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(tick),
		.restart(restart_all),
		.period(trg_per_q[15:0]),
		.running(trg_run),
		.expire(trg_exp)
	);
	acksp_list #(.N(N)) u_list (
		.ref_clk(ref_clk),
		.rst(rst),
		.member(estab_q),
		.arm(send_new || send_old),
		.ack_in(ack_rx),
		.pend_q(pend),
		.all_acked(all_acked)
	);

	// data available latch; a new event wins over its consumption
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			have_new_q <= 1'b0;
		end else if (new_data) begin
			have_new_q <= 1'b1;
		end else if (send_new) begin
			have_new_q <= 1'b0;
		end
	end

	// send decision
	logic running_en;
	assign running_en = mode_q == ACKSP_RUN;
	always_comb begin
		send_new = 1'b0;
		send_old = 1'b0;
		restart_all = 1'b0;
		restart_ack = 1'b0;
		if (running_en) begin
			if (have_new_q && !inh_run && (!ack_pend_q || ack_exp)) begin
				send_new = 1'b1;
				restart_all = 1'b1;
			end else if (trg_exp && !inh_run) begin
				send_old = 1'b1;
				restart_all = 1'b1;
			end else if (ack_exp && ack_pend_q && !lim_q) begin
				send_old = 1'b1;
			end
			restart_ack = send_new || send_old;
		end
	end

	// acknowledge pending: set by any send, cleared by timeout or all acks
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack_pend_q <= 1'b0;
		end else if (send_new || send_old) begin
			ack_pend_q <= 1'b1;
		end else if (ack_exp || all_acked) begin
			ack_pend_q <= 1'b0;
		end
	end

	// retry counter
	logic tmo;
	assign tmo = ack_exp && ack_pend_q && running_en;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rcnt_q <= 8'h0;
		end else if (restart_all) begin
			rcnt_q <= 8'h0;
		end else if (tmo && rcnt_q != 8'hFF) begin
			rcnt_q <= rcnt_q + 8'h1;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lim_q <= 1'b0;
			retry_limit <= 1'b0;
		end else begin
			lim_q <= !restart_all && rcnt_q >= retry_q[7:0];
			retry_limit <= tmo && !restart_all && rcnt_q + 8'h1 == retry_q[7:0];
		end
	end

	// read mux
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h0;
		end else if (req && !wb_we_i) begin
			case (wb_adr_i)
				A_CTRL: wb_dat_o <= ctrl_q;
				A_ACK_PER: wb_dat_o <= ack_per_q;
				A_INH_PER: wb_dat_o <= inh_per_q;
				A_TRG_PER: wb_dat_o <= trg_per_q;
				A_RETRY: wb_dat_o <= retry_q;
				A_TSIZE: wb_dat_o <= tsize_q;
				A_STATUS: wb_dat_o <= {16'h0, rcnt_q, 1'b0, lim_q, err_q,
					ack_pend_q, trg_run, inh_run, ack_run, running_en};
				A_CODES: wb_dat_o <= {16'h0, conn_cfg.cons_code,
					conn_cfg.prod_code};
				A_CPATH: wb_dat_o <= conn_cfg.cons_path_set ?
					{16'h0, TRACKER_CLASS, 8'h01} : 32'h0;
				A_ESTAB: wb_dat_o <= {{(32-N){1'b0}}, estab_q};
				A_PEND: wb_dat_o <= {{(32-N){1'b0}}, pend};
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end

	no_new_inh_a: assert property (@(posedge ref_clk) disable iff (rst)
		inh_run |-> !send_new) else $error("new send while inhibit");
	new_ack_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		send_new |-> !ack_pend_q || ack_exp) else $error("send while pending");
	pend_after_a: assert property (@(posedge ref_clk) disable iff (rst)
		(send_new || send_old) |=> ack_pend_q) else $error("no pending");
	retry_tmo_a: assert property (@(posedge ref_clk) disable iff (rst)
		tmo && !lim_q && !have_new_q && !trg_exp |-> send_old)
		else $error("missed retry");
	new_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
		send_new |=> inh_run || inh_per_q == 32'h0) else $error("inhibit idle");
	clear_count_a: assert property (@(posedge ref_clk) disable iff (rst)
		restart_all |=> rcnt_q == 8'h0) else $error("retry not cleared");
	retry_count_a: assert property (@(posedge ref_clk) disable iff (rst)
		tmo && !restart_all && rcnt_q != 8'hFF |=> rcnt_q == $past(rcnt_q) + 8'h1)
		else $error("retry not counted");
	retry_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
		send_old && !restart_all |=> rcnt_q != 8'h0)
		else $error("resend cleared count");
	fail_commit_a: assert property (@(posedge ref_clk) disable iff (rst)
		commit && !ok_mode |=> mode_q == ACKSP_IDLE && err_q)
		else $error("bad commit accepted");
	wb_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
	limit_pulse_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		retry_limit |=> !retry_limit) else $error("limit held");
	retry_stop_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		tmo && lim_q && !restart_all |-> !send_old) else $error("retry past limit");
	multi_code_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		cfg.multi |=> conn_cfg.cons_code == TT_SRV_CL0) else $error("bad code");
	single_path_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!cfg.multi |=> conn_cfg.cons_path_set) else $error("no path");
	commit_ok_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		commit && ok_mode |=> mode_q == ACKSP_RUN) else $error("commit lost");
	pend_arm_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		(send_new || send_old) && !wr |=> pend == estab_q) else $error("list");
endmodule

// [bench/acksp_peer.sv]
// behavioural model of the remote consumers that return acknowledges
// assumes sent pulses on ref_clk and members mirrors the established list
`timescale 1ns/1ps
module acksp_peer #(
	parameter int DLY = 30
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// producer activity
	input wire logic sent,
	input wire logic [7:0] members,
	input wire logic silent,
	// acknowledges
	output logic [7:0] ack_rx
);
	int cnt;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			ack_rx <= 8'h00;
		end else begin
			ack_rx <= 8'h00;
			if (sent) begin
				cnt <= DLY;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
			// every member answers the latest send as a class 3 server unless silent
			if (cnt == 1 && !silent) begin
				ack_rx <= members;
			end
		end
	end
endmodule

// [bench/acksp_top_test.sv]
// self-checking bench for the acknowledged state-change producer
// assumes the peer model above and a 4 ns ref_clk
`timescale 1ns/1ps
module acksp_top_test;
	import acksp_pkg::*;
	logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [5:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic new_data, support_push, support_cyclic;
	logic send_new, send_old, retry_limit, silent;
	logic [7:0] ack_rx, members;
	acksp_conn_t conn_cfg;
	int err_total, n_checks, n_new, n_old, n_lim;
	acksp_top #(.N(8), .TICK(2)) dut (.ref_clk(ref_clk), .rst(rst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .new_data(new_data),
		.support_push(support_push), .support_cyclic(support_cyclic),
		.send_new(send_new), .send_old(send_old), .retry_limit(retry_limit),
		.ack_rx(ack_rx), .conn_cfg(conn_cfg));
	acksp_peer #(.DLY(30)) peer (.ref_clk(ref_clk), .rst(rst),
		.sent(send_new | send_old), .members(members), .silent(silent),
		.ack_rx(ack_rx));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (send_new === 1'b1) n_new++;
		if (send_old === 1'b1) n_old++;
		if (retry_limit === 1'b1) n_lim++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [5:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) err_total++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic pulse_new();
		@(posedge ref_clk);
		new_data <= 1'b1;
		@(posedge ref_clk);
		new_data <= 1'b0;
	endtask
	task automatic t_reset_regs();
		wb(0, A_ACK_PER, 0); chk(rd, 32'(ACK_PER_RST));
		wb(0, A_INH_PER, 0); chk(rd, 32'(INH_PER_RST));
		wb(0, A_TRG_PER, 0); chk(rd, 32'(TRG_PER_RST));
		wb(0, A_RETRY, 0); chk(rd, 32'(RETRY_RST));
		wb(1, 6'h3C, 32'hFFFFFFFF);
		wb(0, 6'h3C, 0); chk(rd, 32'h0);
	endtask
	task automatic t_codes();
		logic [7:0] pc;
		for (int i = 0; i < 4; i++) begin
			wb(1, A_CMD, 32'h2);
			wb(1, A_TSIZE, 32'h0001_0012);
			wb(1, A_CTRL, 32'(i * 2));
			wb(1, A_CMD, 32'h1);
			pc = i[0] ? (i[1] ? TT_CYC_CL0 : TT_ST_CL0)
				: (i[1] ? TT_CYC_CL3 : TT_ST_CL3);
			@(posedge ref_clk);
			chk(32'(conn_cfg.prod_code), 32'(pc));
			if (i[0]) begin
				chk(32'(conn_cfg.cons_code), 32'(TT_SRV_CL0));
				chk(32'({conn_cfg.cons_size, conn_cfg.cons_path_set}), 0);
			end else begin
				chk(32'(conn_cfg.cons_path_set), 1);
				chk(32'(conn_cfg.cons_size), 32'h12);
				chk(32'(conn_cfg.cons_code), 32'(TT_SRV_CL3));
			end
		end
		wb(1, A_TSIZE, 32'h0000_0012);
		wb(1, A_CTRL, 32'h0);
		@(posedge ref_clk);
		chk(32'(conn_cfg.cons_size), 32'h0);
	endtask
	task automatic t_unsupported();
		wb(1, A_CMD, 32'h2);
		support_cyclic <= 1'b0;
		wb(1, A_CTRL, 32'h4);
		wb(1, A_CMD, 32'h1);
		wb(0, A_STATUS, 0); chk({rd[5], rd[0]}, 32'h2);
		support_cyclic <= 1'b1;
		wb(1, A_CMD, 32'h2);
	endtask
	task automatic t_send();
		wb(1, A_ACK_PER, 32'd20);
		wb(1, A_INH_PER, 32'd5);
		wb(1, A_RETRY, 32'd2);
		wb(1, A_ESTAB, 32'h03);
		members <= 8'h03;
		wb(1, A_CTRL, 32'h0);
		wb(1, A_CMD, 32'h1);
		n_new = 0;
		n_old = 0;
		pulse_new();
		pulse_new();
		chk(n_new, 1);
		wb(0, A_PEND, 0); chk(rd, 32'h03);
		repeat (60) @(posedge ref_clk);
		wb(0, A_PEND, 0); chk(rd, 32'h00);
		chk(n_old, 0);
		chk(n_new, 2);
	endtask
	task automatic t_retry();
		silent <= 1'b1;
		n_old = 0;
		n_lim = 0;
		repeat (60) @(posedge ref_clk);
		pulse_new();
		repeat (100) @(posedge ref_clk);
		wb(0, A_STATUS, 0);
		chk(32'(rd[15:8] != 0), 1);
		chk(32'(n_old != 0), 1);
		repeat (150) @(posedge ref_clk);
		chk(32'(n_lim != 0), 1);
		silent <= 1'b0;
		pulse_new();
		repeat (4) @(posedge ref_clk);
		wb(0, A_STATUS, 0); chk(32'(rd[15:8]), 0);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		finish_test();
	end
	initial begin
		err_total = 0;
		n_checks = 0;
		rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, new_data} = 4'h0;
		wb_adr_i = 6'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		support_push = 1'b1;
		support_cyclic = 1'b1;
		silent = 1'b0;
		members = 8'h00;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset_regs();
		t_codes();
		t_unsupported();
		t_send();
		t_retry();
		finish_test();
	end
endmodule
